// File: rtl/dac_action_core.sv
/*
 * dac register bank with action strobes, output state logic and feedback select.
 * assumes the serial pins and the load/clear pins come from outside the ref_clk domain.
 */
`timescale 1ns/1ns
`default_nettype none
module dac_action_core (
   input wire logic ref_clk,                  // 100 MHz system clock
   input wire logic arst_n,                   // power-on reset, async, active low
   input wire logic sclk,                     // serial clock pin
   input wire logic sync_n,                   // frame select pin, active low
   input wire logic sdin,                     // serial data pin
   input wire logic load_dac_strobe_n,        // external load pin, active low
   input wire logic clear_to_code_n,          // external clear pin, active low
   output logic [dac_pkg::DAC_W-1:0] out_level,  // ladder code driven to the converter
   output logic out_tristate,                 // output stage tristated
   output logic out_clamp,                    // output clamped to analog_ground
   output logic ref_connect,                  // reference inputs connected
   output logic fb_parallel,                  // feedback resistors in parallel
   output logic offset_binary                 // current code format
);
   import dac_pkg::*;

   // =====================================================
   // frame receiver
   logic frm_valid;                           // frame pulse
   frame_t frm;                               // frame content

   frame_receiver u_rx (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sclk(sclk),
      .sync_n(sync_n),
      .sdin(sdin),
      .frm_valid(frm_valid),
      .frm(frm)
   );

   // =====================================================
   // pin synchronisers for load and clear
   logic [1:0] pin_meta_r;                    // first stage, read only by second
   logic load_dac_strobe_s_r, clr_s_r;                   // synced pin levels
   logic load_dac_strobe_prev_r, clr_prev_r;             // previous synced levels

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_r <= 2'h3;
         load_dac_strobe_s_r <= 1'b1;
         clr_s_r <= 1'b1;
         load_dac_strobe_prev_r <= 1'b1;
         clr_prev_r <= 1'b1;
      end else begin
         pin_meta_r <= {load_dac_strobe_n, clear_to_code_n};
         load_dac_strobe_s_r <= pin_meta_r[1];
         clr_s_r <= pin_meta_r[0];
         load_dac_strobe_prev_r <= load_dac_strobe_s_r;
         clr_prev_r <= clr_s_r;
      end
   end

   // =====================================================
   // register bank next values
   logic [DAC_W-1:0] input_r, input_nxt;      // code waiting for a load
   logic [DAC_W-1:0] dac_r, dac_nxt;          // dac register
   logic [DAC_W-1:0] clear_r, clear_nxt;      // stored clear code
   ctrl_t ctrl_r, ctrl_nxt;                   // control register
   logic loaded_r, loaded_nxt;                // dac register written since reset
   logic wr, act, do_reset, do_clear, do_load;  // decoded strobes

   always_comb begin
      wr = frm_valid & ~frm.rw;
      act = wr & (frm.addr == ADDR_ACTION);
      // strobes exist only on this write, never stored
      do_reset = act & frm.data[ACT_RESET];
      // register bit acts as a pin pulse, blocked by the other pin
      do_clear = ((act & frm.data[ACT_CLEAR]) & load_dac_strobe_s_r) | (clr_prev_r & ~clr_s_r);
      do_load = ((act & frm.data[ACT_LOAD]) & clr_s_r) | (load_dac_strobe_prev_r & ~load_dac_strobe_s_r);
      input_nxt = input_r;
      dac_nxt = dac_r;
      clear_nxt = clear_r;
      ctrl_nxt = ctrl_r;
      loaded_nxt = loaded_r;
      if (do_reset) begin
         // software reset: same state as power-up
         input_nxt = CODE_RST;
         dac_nxt = CODE_RST;
         clear_nxt = CODE_RST;
         ctrl_nxt = CTRL_RST;
         loaded_nxt = 1'b0;
      end else begin
         if (wr && frm.addr == ADDR_DAC) begin
            // new code waits for a load
            input_nxt = frm.data;
         end
         if (wr && frm.addr == ADDR_CLEAR) begin
            // 20-bit clear code
            clear_nxt = frm.data;
         end
         if (wr && frm.addr == ADDR_CTRL) begin
            // control fields from their bit positions
            ctrl_nxt.feedback_buffer_select = frm.data[CTRL_FB];
            ctrl_nxt.output_ground_clamp = frm.data[CTRL_GND];
            ctrl_nxt.output_tristate_bit = frm.data[CTRL_TRI];
            ctrl_nxt.code_format_select = frm.data[CTRL_FMT];
         end
         if (do_clear) begin
            // clear wins over a load in the same cycle
            dac_nxt = clear_r;
            loaded_nxt = 1'b1;
         end else if (do_load) begin
            // transfer input code
            dac_nxt = input_r;
            loaded_nxt = 1'b1;
         end
      end
   end

   // =====================================================
   // register bank flip-flops, defaults at power-up
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         input_r <= CODE_RST;
         dac_r <= CODE_RST;
         clear_r <= CODE_RST;
         ctrl_r <= CTRL_RST;
         loaded_r <= 1'b0;
      end else begin
         input_r <= input_nxt;
         dac_r <= dac_nxt;
         clear_r <= clear_nxt;
         ctrl_r <= ctrl_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   // =====================================================
   // output state next values
   logic [DAC_W-1:0] level_r, level_nxt;      // ladder code
   logic tri_r, tri_nxt;                      // tristate
   logic clamp_r, clamp_nxt;                  // ground clamp
   logic refc_r, refc_nxt;                    // references connected
   logic fb_r, fb_nxt;                        // feedback select
   logic fmt_r, fmt_nxt;                      // format shown

   always_comb begin
      // unwritten dac sits at negative reference
      level_nxt = loaded_r ? code_to_level(dac_r, ctrl_r.code_format_select) : LEVEL_NEG;
      // clamp overrides tristate bit
      clamp_nxt = ctrl_r.output_ground_clamp;
      // tristate bit alone, or clamp, tristates the dac
      tri_nxt = ctrl_r.output_tristate_bit | ctrl_r.output_ground_clamp;
      refc_nxt = ~tri_nxt;
      // host picks unity or x2 feedback
      fb_nxt = ctrl_r.feedback_buffer_select;
      fmt_nxt = ctrl_r.code_format_select;
   end

   // =====================================================
   // output flip-flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_r <= LEVEL_NEG;
         tri_r <= 1'b1;
         clamp_r <= 1'b1;
         refc_r <= 1'b0;
         fb_r <= 1'b0;
         fmt_r <= 1'b0;
      end else begin
         level_r <= level_nxt;
         tri_r <= tri_nxt;
         clamp_r <= clamp_nxt;
         refc_r <= refc_nxt;
         fb_r <= fb_nxt;
         fmt_r <= fmt_nxt;
      end
   end

   assign out_level = level_r;
   assign out_tristate = tri_r;
   assign out_clamp = clamp_r;
   assign ref_connect = refc_r;
   assign fb_parallel = fb_r;
   assign offset_binary = fmt_r;

   // =====================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   load_update_a: assert property (
      (act && frm.data[2:0] == 3'h1 && clr_s_r && !(clr_prev_r && !clr_s_r))
      |=> (dac_r == $past(input_r)) && loaded_r ##1 (out_tristate || out_level == code_to_level(dac_r, fmt_r))
   ) else $error("load strobe did not transfer the input code");

   clear_load_a: assert property (
      (act && frm.data[2:0] == 3'h2 && load_dac_strobe_s_r) |=> dac_r == $past(clear_r)
   ) else $error("clear strobe did not load the clear code");

   soft_reset_a: assert property (
      (act && frm.data[ACT_RESET])
      |=> (ctrl_r == CTRL_RST && dac_r == CODE_RST && !loaded_r) ##1 (out_clamp && out_tristate && !ref_connect)
   ) else $error("software reset did not restore power-up state");

   clear_blocked_a: assert property (
      (act && frm.data[2:0] == 3'h2 && !load_dac_strobe_s_r && !load_dac_strobe_prev_r && clr_s_r) |=> $stable(dac_r)
   ) else $error("clear strobe acted while load pin low");

   load_blocked_a: assert property (
      (act && frm.data[2:0] == 3'h1 && !clr_s_r && !clr_prev_r && load_dac_strobe_s_r) |=> $stable(dac_r) && $stable(loaded_r)
   ) else $error("load strobe acted while clear pin low");

   read_ignored_a: assert property (
      (frm_valid && frm.rw && load_dac_strobe_s_r && clr_s_r && load_dac_strobe_prev_r && clr_prev_r)
      |=> $stable(ctrl_r) && $stable(dac_r) && $stable(clear_r)
   ) else $error("read frame changed register state");

   power_clamp_a: assert property (
      ctrl_r.output_ground_clamp |=> out_clamp && out_tristate && !ref_connect
   ) else $error("clamp bit set but output not clamped");

   tristate_only_a: assert property (
      (ctrl_r.output_tristate_bit && !ctrl_r.output_ground_clamp) |=> out_tristate && !out_clamp
   ) else $error("tristate bit did not tristate the output");

   normal_mode_a: assert property (
      (!ctrl_r.output_tristate_bit && !ctrl_r.output_ground_clamp) |=> !out_tristate && !out_clamp && ref_connect
   ) else $error("normal mode not entered");

   unwritten_level_a: assert property (
      !loaded_r |=> out_level == LEVEL_NEG
   ) else $error("unwritten dac not at negative reference");

   twos_format_a: assert property (
      (loaded_r && !ctrl_r.code_format_select) |=> out_level == ($past(dac_r) ^ TWOS_FLIP)
   ) else $error("twos complement conversion wrong");

   no_store_a: assert property (
      (act && frm.data[2:0] == 3'h0 && load_dac_strobe_s_r && clr_s_r && load_dac_strobe_prev_r && clr_prev_r) |=> $stable(dac_r)
   ) else $error("action write with no bits changed the dac");

endmodule // dac_action_core
`default_nettype wire

// File: shared/dac_pkg.sv
/*
 * constants, types and helper functions shared by the dac action block and its serial frame receiver.
 * assumes a single 100 MHz ref_clk domain; serial pins are sampled, never used as clocks.
 */
// Function
// - load bit transfers input code to dac
// - clear bit loads stored clear code
// - reset bit restores full power-up state
// - clear action ignored while load pin low
// - load action ignored while clear pin low
// - action register: write, address 100, reserved bits
// - power-up sets every register to default
// - power-up: tristated, refs off, output clamped
// - unwritten dac gives negative reference level
// - tristate bit alone tristates, both clear normal
// - clamp bit clamps output whatever tristate holds
// - format 0 twos complement, 1 offset binary
// - clear code register, address 011, 20 bits
// - action bits act like pulsing matching pins
`default_nettype none
package dac_pkg;

   // =====================================================
   // frame layout
   localparam int FRAME_BITS = 24;      // bits in one serial frame
   localparam int DAC_W = 20;           // dac code width
   localparam int CNT_W = 5;            // frame bit counter width

   typedef struct packed {
      logic rw;                        // 1 = read, 0 = write
      logic [2:0] addr;                // register address
      logic [DAC_W-1:0] data;          // register data
   } frame_t;

   // =====================================================
   // register addresses
   localparam logic [2:0] ADDR_DAC = 3'h1;     // dac input code
   localparam logic [2:0] ADDR_CTRL = 3'h2;    // control register
   localparam logic [2:0] ADDR_CLEAR = 3'h3;   // clear code
   localparam logic [2:0] ADDR_ACTION = 3'h4;  // action strobes

   // =====================================================
   // action register bit positions
   localparam int ACT_LOAD = 0;        // load strobe
   localparam int ACT_CLEAR = 1;       // clear-to-code strobe
   localparam int ACT_RESET = 2;       // full reset

   // =====================================================
   // control register layout
   localparam int CTRL_FB = 1;         // feedback buffer select position
   localparam int CTRL_GND = 2;        // output ground clamp position
   localparam int CTRL_TRI = 3;        // output tristate position
   localparam int CTRL_FMT = 4;        // code format select position

   typedef struct packed {
      logic code_format_select;        // 0 twos complement, 1 offset binary
      logic output_tristate_bit;       // 1 tristates the output
      logic output_ground_clamp;       // 1 clamps the output to ground
      logic feedback_buffer_select;    // 1 parallel feedback resistors
   } ctrl_t;

   // =====================================================
   // reset values
   localparam ctrl_t CTRL_RST = '{code_format_select: 1'b0, output_tristate_bit: 1'b1,
                                  output_ground_clamp: 1'b1, feedback_buffer_select: 1'b0};
   localparam logic [DAC_W-1:0] CODE_RST = 20'h0_0000;     // input, dac and clear codes
   localparam logic [DAC_W-1:0] LEVEL_NEG = 20'h0_0000;    // ladder code at negative reference
   localparam logic [DAC_W-1:0] TWOS_FLIP = 20'h8_0000;    // sign bit flip for twos complement

   // ladder code from a register code under the selected format
   function automatic logic [DAC_W-1:0] code_to_level(input logic [DAC_W-1:0] code, input logic offset_bin);
      code_to_level = offset_bin ? code : (code ^ TWOS_FLIP);
   endfunction

endpackage
`default_nettype wire

// File: rtl/frame_receiver.sv
/*
 * serial frame receiver: samples the 3-wire port pins, shifts data on serial clock falling edges.
 * assumes sclk is much slower than ref_clk (at least four ref_clk periods per sclk half period).
 */
`timescale 1ns/1ns
`default_nettype none
module frame_receiver (
   input wire logic ref_clk,                  // system clock
   input wire logic arst_n,                   // async reset, active low
   input wire logic sclk,                     // serial clock pin
   input wire logic sync_n,                   // frame select pin, active low
   input wire logic sdin,                     // serial data pin
   output logic frm_valid,                    // one-cycle pulse, whole frame taken
   output dac_pkg::frame_t frm                // frame content, valid with frm_valid
);
   import dac_pkg::*;

   // =====================================================
   // pin synchronisers and state
   logic [2:0] meta_r;                        // first stage, read only by second
   logic [2:0] pin_r;                         // second stage: sclk, sync_n, sdin
   logic sclk_prev_r, sync_prev_r;            // previous synced levels
   logic [FRAME_BITS-1:0] shift_r, shift_nxt; // shift register
   logic [CNT_W-1:0] cnt_r, cnt_nxt;          // bits taken in this frame
   logic valid_r, valid_nxt;                  // frame pulse
   frame_t frm_r, frm_nxt;                    // latched frame
   logic fall, frame_end;                     // detected events

   // =====================================================
   // next values
   always_comb begin
      fall = sclk_prev_r & ~pin_r[2] & ~pin_r[1];
      frame_end = ~sync_prev_r & pin_r[1];
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      valid_nxt = 1'b0;
      frm_nxt = frm_r;
      if (sync_prev_r && !pin_r[1]) begin
         // frame start clears the count
         cnt_nxt = '0;
      end else if (fall) begin
         // msb first, count saturates on overlong frames
         shift_nxt = {shift_r[FRAME_BITS-2:0], pin_r[0]};
         if (cnt_r != '1) begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
      if (frame_end && cnt_r == CNT_W'(FRAME_BITS)) begin
         // only exact-length frames are taken
         valid_nxt = 1'b1;
         frm_nxt = frame_t'(shift_r);
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // idle levels, sclk and sync_n high, so no false edge follows reset
         meta_r <= 3'h6;
         pin_r <= 3'h6;
         sclk_prev_r <= 1'b1;
         sync_prev_r <= 1'b1;
         shift_r <= '0;
         cnt_r <= '0;
         valid_r <= 1'b0;
         frm_r <= '0;
      end else begin
         meta_r <= {sclk, sync_n, sdin};
         pin_r <= meta_r;
         sclk_prev_r <= pin_r[2];
         sync_prev_r <= pin_r[1];
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         valid_r <= valid_nxt;
         frm_r <= frm_nxt;
      end
   end

   assign frm_valid = valid_r;
   assign frm = frm_r;

endmodule // frame_receiver
`default_nettype wire

// File: verif/host_serial_model.sv
/*
 * host side of the 3-wire port: sends whole 24-bit frames, msb first.
 * assumes ref_clk at 100 MHz paces it; sclk is 160 ns, idle high, still between frames.
 */
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
   input wire logic ref_clk,  // bench clock, pacing only
   output logic sclk,         // serial clock, stands high outside frames
   output logic sync_n,       // frame select, active low
   output logic sdin          // serial data
);
   import dac_pkg::*;
   // =====================================================
   // idle pins at time zero
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdin = 1'b0;
   end
   // half a serial period, changes land just after a falling ref_clk edge
   task automatic half();
      repeat (8) @(negedge ref_clk);
   endtask
   // =====================================================
   // one frame: bit set while sclk high, taken on its fall
   task automatic send(input frame_t f);
      logic [FRAME_BITS-1:0] bits;
      bits = f;
      sync_n = 1'b0;
      for (int i = FRAME_BITS - 1; i >= 0; i--) begin
         sdin = bits[i];
         half();
         sclk = 1'b0;
         half();
         sclk = 1'b1;
      end
      half();
      sync_n = 1'b1;
      sdin = ~sdin; // deselected line must not show the last bit
      half();
   endtask
endmodule // host_serial_model
`default_nettype wire

// File: verif/tb.sv
/*
 * self-checking bench for the dac action block, host frames through the serial model.
 * assumes the design package is compiled first; expectations come from the bench only.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
   import dac_pkg::*;
   // =====================================================
   // signals
   logic ref_clk = 1'b0;          // 100 MHz clock
   logic arst_n = 1'b0;           // power-on reset
   logic load_dac_strobe_n = 1'b1; // load pin, idle high
   logic clear_to_code_n = 1'b1;  // clear pin, idle high
   wire logic sclk;               // serial clock from host
   wire logic sync_n;             // frame select from host
   wire logic sdin;               // serial data from host
   logic [DAC_W-1:0] out_level;   // ladder code
   logic out_tristate;            // tristate flag
   logic out_clamp;               // clamp flag
   logic ref_connect;             // references on
   logic fb_parallel;             // feedback select
   logic offset_binary;           // format
   int checks = 0;                // comparisons made
   int mismatches = 0;            // comparisons failed

   always #5 ref_clk = ~ref_clk;  // 10 ns period

   host_serial_model i_host (.ref_clk(ref_clk), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));

   dac_action_core i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
      .load_dac_strobe_n(load_dac_strobe_n), .clear_to_code_n(clear_to_code_n), .out_level(out_level),
      .out_tristate(out_tristate), .out_clamp(out_clamp), .ref_connect(ref_connect),
      .fb_parallel(fb_parallel), .offset_binary(offset_binary));

   // =====================================================
   // shared tasks
   task automatic settle();
      repeat (10) @(negedge ref_clk);
   endtask
   // write frame then let outputs land
   task automatic wr(input logic [2:0] a, input logic [DAC_W-1:0] d);
      i_host.send('{rw: 1'b0, addr: a, data: d});
      settle();
   endtask
   // control register write
   task automatic ctrl(input logic fmt, input logic tri_b, input logic gnd, input logic fb);
      logic [DAC_W-1:0] d;
      d = 20'h0_0000;
      d[CTRL_FMT] = fmt;
      d[CTRL_TRI] = tri_b;
      d[CTRL_GND] = gnd;
      d[CTRL_FB] = fb;
      wr(ADDR_CTRL, d);
   endtask
   // compare all outputs; references connect exactly when not tristated
   task automatic expect_out(input logic [DAC_W-1:0] lv, input logic tri_b, input logic gnd,
                             input logic fb, input logic fmt);
      `CHK(out_level, lv)
      `CHK(out_tristate, tri_b)
      `CHK(out_clamp, gnd)
      `CHK(ref_connect, ~tri_b)
      `CHK(fb_parallel, fb)
      `CHK(offset_binary, fmt)
   endtask
   // verdict
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // =====================================================
   // scenarios
   task automatic t_power_up();
      expect_out(20'h0_0000, 1'b1, 1'b1, 1'b0, 1'b0);
   endtask
   // all four tristate/clamp combinations, ending in normal mode before any load
   task automatic t_out_states();
      logic [1:0] s;
      for (int i = 3; i >= 0; i--) begin
         s = i[1:0];
         ctrl(1'b0, s[1], s[0], 1'b0);
         expect_out(20'h0_0000, s[1] | s[0], s[0], 1'b0, 1'b0);
      end
   endtask
   task automatic t_feedback();
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      expect_out(20'h0_0000, 1'b0, 1'b0, 1'b1, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0);
      expect_out(20'h0_0000, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   // input write alone does nothing; reserved bits and read frames do nothing
   task automatic t_load();
      wr(ADDR_DAC, 20'h1_2345);
      `CHK(out_level, 20'h0_0000)
      wr(ADDR_ACTION, 20'h0_0001);
      `CHK(out_level, 20'h9_2345)
      wr(ADDR_DAC, 20'h0_00aa);
      wr(ADDR_ACTION, 20'hf_fff8);
      `CHK(out_level, 20'h9_2345)
      i_host.send('{rw: 1'b1, addr: ADDR_ACTION, data: 20'h0_0001});
      settle();
      `CHK(out_level, 20'h9_2345)
      wr(ADDR_ACTION, 20'h0_0001);
      `CHK(out_level, 20'h8_00aa)
   endtask
   // clear code under both formats
   task automatic t_clear();
      wr(ADDR_CLEAR, 20'h3_c001);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      wr(ADDR_ACTION, 20'h0_0002);
      expect_out(20'h3_c001, 1'b0, 1'b0, 1'b0, 1'b1);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0);
      wr(ADDR_ACTION, 20'h0_0002);
      `CHK(out_level, 20'hb_c001)
   endtask
   // pin pulses act; a held pin blocks the other action
   task automatic t_pins();
      wr(ADDR_DAC, 20'h0_5555);
      load_dac_strobe_n = 1'b0;
      settle();
      `CHK(out_level, 20'h8_5555)
      wr(ADDR_ACTION, 20'h0_0002);
      `CHK(out_level, 20'h8_5555)
      load_dac_strobe_n = 1'b1;
      settle();
      clear_to_code_n = 1'b0;
      settle();
      `CHK(out_level, 20'hb_c001)
      wr(ADDR_DAC, 20'h0_7777);
      wr(ADDR_ACTION, 20'h0_0001);
      `CHK(out_level, 20'hb_c001)
      clear_to_code_n = 1'b1;
      settle();
      wr(ADDR_ACTION, 20'h0_0001);
      `CHK(out_level, 20'h8_7777)
   endtask
   // software reset returns outputs and the clear code to power-up values
   task automatic t_soft_reset();
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      wr(ADDR_ACTION, 20'h0_0004);
      expect_out(20'h0_0000, 1'b1, 1'b1, 1'b0, 1'b0);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      wr(ADDR_ACTION, 20'h0_0002);
      expect_out(20'h0_0000, 1'b0, 1'b0, 1'b0, 1'b1);
      // input code was reset too, so a load gives code zero
      wr(ADDR_ACTION, 20'h0_0001);
      `CHK(out_level, 20'h0_0000)
   endtask

   // =====================================================
   // main sequence
   initial begin
      repeat (8) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_power_up();
      t_out_states();
      t_feedback();
      t_load();
      t_clear();
      t_pins();
      t_soft_reset();
      close_out();
   end
   // watchdog well beyond the expected run of about 11000 cycles
   initial begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
endmodule // tb
`default_nettype wire
